// >>> hdl/lft_frame_table.sv
// Frame slot tables, header matching, sporadic choice and signal slot stream
`timescale 1ns/1ps
// Operation
// (RULE1) Twenty-five independent unconditional frame slots
// (RULE2) Each slot direction: undefined, publish or subscribe
// (RULE3) Checksum classic or enhanced, classic by default
// (RULE4) Up to fifteen signal slots carry payload
// (RULE5) Signal slot: index 0-130, bit offset 0-63
// (RULE6) Signal index zero means slot unused
// (RULE7) One event frame, five refs, zero is none
// (RULE8) Collision table index zero means none defined
// (RULE9) Event members share size and checksum
// (RULE10) Event members marked as event-associated
// (RULE11) Sporadic frame works only in master mode
// (RULE12) Sporadic priority: reference one highest
// (RULE13) Sporadic reference zero excluded from choice
// (RULE14) Collision table: five unconditional entries, master only
// (RULE15) Six-bit identifier, one to eight bytes
// (RULE16) Sporadic sends highest updated frame, else nothing

// ****************************************
// Slot descriptor FIFO
// ****************************************
module lft_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = lft_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Honest flags straight from the count
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb
  begin
    wr_d = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; only valid entries are ever read
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end
endmodule : lft_fifo

// ****************************************
// Frame table top
// ****************************************
module lft_frame_table #(
  parameter int NF = lft_pkg::NUM_FRAMES,
  parameter int NS = lft_pkg::NUM_SIG_SLOTS,
  parameter int NR = lft_pkg::NUM_REFS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration write
  input wire logic cfg_we,
  input wire logic [2:0] cfg_target,
  input wire logic [4:0] cfg_frame,
  input wire logic [3:0] cfg_slot,
  input wire logic [1:0] cfg_kind,
  input wire logic [5:0] cfg_id,
  input wire logic [3:0] cfg_size,
  input wire logic cfg_cks,
  input wire logic cfg_assoc,
  input wire logic [7:0] cfg_sig,
  input wire logic [5:0] cfg_off,
  input wire logic [4:0] cfg_num,
  output logic cfg_err,
  // Node role
  input wire logic master_mode,
  // Header match
  input wire logic hdr_valid,
  input wire logic [5:0] hdr_id,
  output logic m_valid,
  output logic m_hit,
  output logic m_event,
  output logic [4:0] m_frame,
  output logic [1:0] m_kind,
  output logic [3:0] m_size,
  output logic m_cks,
  output logic [4:0] m_coll_tbl,
  // Signal updates and sporadic slot
  input wire logic upd_valid,
  input wire logic [4:0] upd_frame,
  input wire logic spor_req,
  output logic spor_valid,
  output logic [4:0] spor_frame,
  // Collision table lookup
  input wire logic coll_req,
  input wire logic [2:0] coll_entry,
  output logic coll_valid,
  output logic [4:0] coll_frame,
  // Signal slot stream
  output logic slot_valid,
  input wire logic slot_ready,
  output logic [7:0] slot_sig,
  output logic [5:0] slot_off,
  output logic slot_last,
  output logic walk_busy
);
  import lft_pkg::*;

  // ****************************************
  // Configuration tables
  // ****************************************
  logic [1:0] fr_kind_q [1:NF];
  logic [5:0] fr_id_q [1:NF];
  logic [3:0] fr_size_q [1:NF];
  logic fr_cks_q [1:NF];
  logic fr_assoc_q [1:NF];
  logic [7:0] sl_sig_q [1:NF][NS];
  logic [5:0] sl_off_q [1:NF][NS];
  logic [1:0] etf_kind_q;
  logic [5:0] etf_id_q;
  logic [3:0] etf_size_q;
  logic etf_cks_q;
  logic [4:0] etf_coll_q;
  logic [4:0] etf_ref_q [NR];
  logic [1:0] spor_kind_q;
  logic [4:0] spor_ref_q [NR];
  logic [4:0] coll_ref_q [NR];

  // Range checks shared by the frame, signal and reference targets
  function automatic logic frame_ok(input logic [4:0] f);
    frame_ok = (f != 5'h00) && (f <= FRAME_MAX);
  endfunction : frame_ok

  function automatic logic ref_ok(input logic [4:0] n, input logic [3:0] s);
    ref_ok = (n <= FRAME_MAX) && (s < 4'(NR));
  endfunction : ref_ok

  logic wr_ok;
  // Out-of-range writes are dropped whole, never clipped
  always_comb
  begin
    case (cfg_target)
      TGT_FRAME: wr_ok = frame_ok(cfg_frame) && cfg_size >= SIZE_MIN && cfg_size <= SIZE_MAX
                         && cfg_kind <= KIND_SUBSCRIBE; // see (RULE15)
      TGT_SIGNAL: wr_ok = frame_ok(cfg_frame) && cfg_slot < 4'(NS) && cfg_sig <= SIG_MAX; // see (RULE5)
      TGT_ETF: wr_ok = cfg_size >= SIZE_MIN && cfg_size <= SIZE_MAX && cfg_num <= COLL_TBL_MAX
                       && cfg_kind <= KIND_SUBSCRIBE;
      TGT_ETF_REF: wr_ok = ref_ok(cfg_num, cfg_slot); // see (RULE7)
      TGT_SPOR: wr_ok = cfg_kind <= KIND_SUBSCRIBE;
      TGT_SPOR_REF: wr_ok = ref_ok(cfg_num, cfg_slot);
      TGT_COLL: wr_ok = ref_ok(cfg_num, cfg_slot); // see (RULE14)
      default: wr_ok = 1'b0;
    endcase
  end

  // Table writes; defaults give classic checksum and size one
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int f = 1; f <= NF; f++)
      begin
        fr_kind_q[f] <= RST_KIND; // see (RULE1) (RULE2)
        fr_id_q[f] <= RST_ID;
        fr_size_q[f] <= RST_SIZE;
        fr_cks_q[f] <= RST_CKS; // see (RULE3)
        fr_assoc_q[f] <= RST_ASSOC;
        for (int s = 0; s < NS; s++)
        begin
          sl_sig_q[f][s] <= RST_SIG;
          sl_off_q[f][s] <= RST_OFF;
        end
      end
      for (int r = 0; r < NR; r++)
      begin
        etf_ref_q[r] <= RST_NUM;
        spor_ref_q[r] <= RST_NUM;
        coll_ref_q[r] <= RST_NUM;
      end
      etf_kind_q <= RST_KIND;
      etf_id_q <= RST_ID;
      etf_size_q <= RST_SIZE;
      etf_cks_q <= RST_CKS;
      etf_coll_q <= RST_NUM;
      spor_kind_q <= RST_KIND;
      cfg_err <= 1'b0;
    end
    else if (cfg_we)
    begin
      cfg_err <= !wr_ok;
      if (wr_ok)
      begin
        case (cfg_target)
          TGT_FRAME:
          begin
            fr_kind_q[cfg_frame] <= cfg_kind;
            fr_id_q[cfg_frame] <= cfg_id;
            fr_size_q[cfg_frame] <= cfg_size;
            fr_cks_q[cfg_frame] <= cfg_cks;
            fr_assoc_q[cfg_frame] <= cfg_assoc; // see (RULE10)
          end
          TGT_SIGNAL:
          begin
            sl_sig_q[cfg_frame][cfg_slot] <= cfg_sig; // see (RULE4)
            sl_off_q[cfg_frame][cfg_slot] <= cfg_off;
          end
          TGT_ETF:
          begin
            etf_kind_q <= cfg_kind;
            etf_id_q <= cfg_id;
            etf_size_q <= cfg_size;
            etf_cks_q <= cfg_cks;
            etf_coll_q <= cfg_num; // see (RULE8)
          end
          TGT_ETF_REF: etf_ref_q[cfg_slot[2:0]] <= cfg_num;
          TGT_SPOR: spor_kind_q <= cfg_kind;
          TGT_SPOR_REF: spor_ref_q[cfg_slot[2:0]] <= cfg_num;
          TGT_COLL: coll_ref_q[cfg_slot[2:0]] <= cfg_num;
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // Header match, sporadic choice, collision lookup
  // ****************************************
  logic [4:0] hit_fr, pick_fr;
  logic hit_etf, etf_any;
  logic [NF:1] pend_q, pend_d;
  logic [4:0] m_frame_d, spor_frame_d, coll_frame_d;
  logic m_hit_d, m_event_d, m_cks_d;
  logic [1:0] m_kind_d;
  logic [3:0] m_size_d;
  logic [4:0] m_coll_d;

  // Lowest defined slot wins if identifiers collide
  always_comb
  begin
    hit_fr = 5'h00;
    for (int f = NF; f >= 1; f--)
    begin
      if (fr_kind_q[f] != KIND_UNDEF && fr_id_q[f] == hdr_id)
        hit_fr = 5'(f); // see (RULE15)
    end
    etf_any = 1'b0;
    for (int r = 0; r < NR; r++)
      etf_any = etf_any || (etf_ref_q[r] != 5'h00); // see (RULE7)
    hit_etf = (hit_fr == 5'h00) && etf_any && etf_kind_q != KIND_UNDEF && etf_id_q == hdr_id;
  end

  // Slot one scanned last so it takes precedence
  always_comb
  begin
    pick_fr = 5'h00;
    for (int r = NR - 1; r >= 0; r--)
    begin
      if (spor_ref_q[r] != 5'h00 && pend_q[spor_ref_q[r]]) // see (RULE13) (RULE16)
        pick_fr = spor_ref_q[r]; // see (RULE12)
    end
    if (!master_mode || spor_kind_q == KIND_UNDEF)
      pick_fr = 5'h00; // see (RULE11)
  end

  // Match results, sporadic result and pending flags
  always_comb
  begin
    m_hit_d = hit_fr != 5'h00 || hit_etf;
    m_event_d = hit_etf;
    m_frame_d = hit_fr;
    m_kind_d = hit_etf ? etf_kind_q : (hit_fr != 5'h00 ? fr_kind_q[hit_fr] : KIND_UNDEF);
    m_size_d = hit_etf ? etf_size_q : (hit_fr != 5'h00 ? fr_size_q[hit_fr] : RST_SIZE);
    m_cks_d = hit_etf ? etf_cks_q : (hit_fr != 5'h00 ? fr_cks_q[hit_fr] : RST_CKS);
    m_coll_d = (hit_etf && master_mode) ? etf_coll_q : 5'h00; // see (RULE8)
    spor_frame_d = spor_req ? pick_fr : 5'h00;
    // Collision entries only name unconditional frames, master only
    coll_frame_d = (master_mode && etf_coll_q != 5'h00 && coll_entry < 3'(NR))
                   ? coll_ref_q[coll_entry] : 5'h00; // see (RULE14)
    pend_d = pend_q;
    if (spor_frame_d != 5'h00)
      pend_d[spor_frame_d] = 1'b0;
    // Set after clear: an update in the send cycle is kept
    if (upd_valid && frame_ok(upd_frame))
      pend_d[upd_frame] = 1'b1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      m_valid <= 1'b0;
      m_hit <= 1'b0;
      m_event <= 1'b0;
      m_frame <= 5'h00;
      m_kind <= KIND_UNDEF;
      m_size <= RST_SIZE;
      m_cks <= RST_CKS;
      m_coll_tbl <= 5'h00;
      spor_valid <= 1'b0;
      spor_frame <= 5'h00;
      coll_valid <= 1'b0;
      coll_frame <= 5'h00;
      pend_q <= '0;
    end
    else
    begin
      m_valid <= hdr_valid;
      if (hdr_valid)
      begin
        m_hit <= m_hit_d;
        m_event <= m_event_d;
        m_frame <= m_frame_d;
        m_kind <= m_kind_d;
        m_size <= m_size_d;
        m_cks <= m_cks_d;
        m_coll_tbl <= m_coll_d;
      end
      spor_valid <= spor_req;
      if (spor_req)
        spor_frame <= spor_frame_d;
      coll_valid <= coll_req;
      if (coll_req)
        coll_frame <= coll_frame_d;
      pend_q <= pend_d;
    end
  end

  // ****************************************
  // Signal slot walker
  // ****************************************
  lft_walk_e st_q, st_d;
  logic [4:0] wfr_q, wfr_d, start_fr;
  logic [3:0] wsl_q, wsl_d;
  logic used, later, push, in_ready, adv;

  // Sporadic choice outranks a header match in the same cycle
  assign start_fr = (spor_frame_d != 5'h00) ? spor_frame_d : ((hdr_valid && !hit_etf) ? hit_fr : 5'h00);

  always_comb
  begin
    used = (st_q == LFT_WALK) && sl_sig_q[wfr_q][wsl_q] != RST_SIG; // see (RULE6)
    later = 1'b0;
    for (int s = 0; s < NS; s++)
    begin
      if (4'(s) > wsl_q && sl_sig_q[wfr_q][s] != RST_SIG)
        later = 1'b1;
    end
    push = used;
    // Stalls here when a used slot meets a full buffer
    adv = !used || in_ready;
    st_d = st_q;
    wfr_d = wfr_q;
    wsl_d = wsl_q;
    case (st_q)
      LFT_IDLE:
      begin
        if (start_fr != 5'h00)
        begin
          st_d = LFT_WALK;
          wfr_d = start_fr;
          wsl_d = 4'h0;
        end
      end
      LFT_WALK:
      begin
        if (adv)
        begin
          if (wsl_q == 4'(NS - 1))
            st_d = LFT_IDLE;
          else
            wsl_d = wsl_q + 4'h1;
        end
      end
      default: st_d = LFT_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= LFT_IDLE;
      wfr_q <= 5'h01;
      wsl_q <= 4'h0;
      walk_busy <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      wfr_q <= wfr_d;
      wsl_q <= wsl_d;
      walk_busy <= st_d == LFT_WALK;
    end
  end

  // Descriptors: signal index, bit offset, last-of-frame
  lft_fifo #(
    .WIDTH(15),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data({sl_sig_q[wfr_q][wsl_q], sl_off_q[wfr_q][wsl_q], !later}), // see (RULE4) (RULE5)
    .out_valid(slot_valid),
    .out_ready(slot_ready),
    .out_data({slot_sig, slot_off, slot_last})
  );
endmodule : lft_frame_table

// >>> hdl/lft_pkg.sv
// Constants, codes and reset values shared by the frame table logic
package lft_pkg;

  // ****************************************
  // Table dimensions
  // ****************************************
  localparam int NUM_FRAMES = 25;
  localparam int NUM_SIG_SLOTS = 15;
  localparam int NUM_REFS = 5;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] SIG_MAX = 8'h82;
  localparam logic [4:0] FRAME_MAX = 5'h19;
  localparam logic [3:0] SIZE_MIN = 4'h1;
  localparam logic [3:0] SIZE_MAX = 4'h8;
  localparam logic [4:0] COLL_TBL_MAX = 5'h01;

  // ****************************************
  // Field codes
  // ****************************************
  localparam logic [1:0] KIND_UNDEF = 2'h0;
  localparam logic [1:0] KIND_PUBLISH = 2'h1;
  localparam logic [1:0] KIND_SUBSCRIBE = 2'h2;
  localparam logic CKS_CLASSIC = 1'b0;
  localparam logic CKS_ENHANCED = 1'b1;

  // ****************************************
  // Configuration write targets
  // ****************************************
  localparam logic [2:0] TGT_FRAME = 3'h0;
  localparam logic [2:0] TGT_SIGNAL = 3'h1;
  localparam logic [2:0] TGT_ETF = 3'h2;
  localparam logic [2:0] TGT_ETF_REF = 3'h3;
  localparam logic [2:0] TGT_SPOR = 3'h4;
  localparam logic [2:0] TGT_SPOR_REF = 3'h5;
  localparam logic [2:0] TGT_COLL = 3'h6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [1:0] RST_KIND = KIND_UNDEF;
  localparam logic [5:0] RST_ID = 6'h00;
  localparam logic [3:0] RST_SIZE = 4'h1;
  localparam logic RST_CKS = CKS_CLASSIC;
  localparam logic RST_ASSOC = 1'b0;
  localparam logic [7:0] RST_SIG = 8'h00;
  localparam logic [5:0] RST_OFF = 6'h00;
  localparam logic [4:0] RST_NUM = 5'h00;

  // Walker states, one-hot
  typedef enum logic [1:0] {
    LFT_IDLE = 2'b01,
    LFT_WALK = 2'b10
  } lft_walk_e;

endpackage : lft_pkg

// >>> verif/lft_node_model.sv
// Far-side node model that takes the signal slot stream
`timescale 1ns/1ps
// ****************************************
// Slot consumer
// ****************************************
module lft_node_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Stream from the frame table
  input wire logic slot_valid,
  output logic slot_ready,
  input wire logic [7:0] slot_sig,
  input wire logic [5:0] slot_off,
  input wire logic slot_last,
  // Stall control from the bench
  input wire logic stall
);
  logic [14:0] got[$];
  // Ready drops while stalled, so the table must hold its head
  assign slot_ready = !stall;
  // Each taken slot becomes one payload field of the frame
  always @(posedge clk)
    if (rstn && slot_valid && slot_ready)
      got.push_back({slot_sig, slot_off, slot_last});
endmodule : lft_node_model

// >>> verif/lft_sva.sv
// Port assertions for the frame table top
`timescale 1ns/1ps
// ****************************************
// Checker
// ****************************************
module lft_sva
  import lft_pkg::*;
#(
  parameter int NF = NUM_FRAMES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration
  input wire logic cfg_we,
  input wire logic [2:0] cfg_target,
  input wire logic [4:0] cfg_frame,
  input wire logic [3:0] cfg_size,
  input wire logic [7:0] cfg_sig,
  input wire logic cfg_err,
  // Requests and answers
  input wire logic master_mode,
  input wire logic hdr_valid,
  input wire logic m_valid,
  input wire logic m_event,
  input wire logic [1:0] m_kind,
  input wire logic [4:0] m_coll_tbl,
  input wire logic spor_req,
  input wire logic spor_valid,
  input wire logic [4:0] spor_frame,
  input wire logic coll_req,
  input wire logic [2:0] coll_entry,
  input wire logic coll_valid,
  input wire logic [4:0] coll_frame,
  // Slot stream
  input wire logic slot_valid,
  input wire logic slot_ready,
  input wire logic [7:0] slot_sig,
  input wire logic [5:0] slot_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Answers come exactly one cycle after the request
  a_hdr_answer: assert property (hdr_valid |=> m_valid) else $error("no match answer");
  a_hdr_no_extra: assert property (!hdr_valid |=> !m_valid) else $error("stray match answer");
  a_kind_legal: assert property (m_valid |-> m_kind != 2'h3) else $error("illegal kind");
  a_coll_tbl_gate: assert property (m_valid && !m_event |-> m_coll_tbl == 5'h00) else $error("coll table leak");
  a_spor_slave_quiet: assert property (
    spor_req && !master_mode |=> spor_valid && spor_frame == 5'h00)
    else $error("sporadic in slave");
  a_spor_range: assert property (
    spor_req |=> spor_valid && spor_frame <= FRAME_MAX)
    else $error("sporadic pick bad");
  a_coll_gate: assert property (
    coll_req && (!master_mode || coll_entry > 3'h4) |=> coll_valid && coll_frame == 5'h00)
    else $error("collision entry leak");
  a_frame_refused: assert property (
    cfg_we && cfg_target == TGT_FRAME && (cfg_frame == 5'h00 || cfg_frame > NF) |=> cfg_err)
    else $error("bad frame accepted");
  a_size_refused: assert property (
    cfg_we && cfg_target == TGT_FRAME && (cfg_size < SIZE_MIN || cfg_size > SIZE_MAX) |=> cfg_err)
    else $error("bad size accepted");
  a_sig_refused: assert property (
    cfg_we && cfg_target == TGT_SIGNAL && cfg_sig > SIG_MAX |=> cfg_err)
    else $error("bad signal accepted");
  a_slot_used: assert property (
    slot_valid |-> slot_sig != 8'h00 && slot_sig <= SIG_MAX)
    else $error("unused slot streamed");
  a_slot_hold: assert property (
    slot_valid && !slot_ready |=> slot_valid && $stable(slot_sig) && $stable(slot_off))
    else $error("slot head moved");
  // Main scenarios reached
  c_event_hit: cover property (m_valid && m_event && m_coll_tbl != 5'h00);
  c_spor_pick: cover property (spor_valid && spor_frame != 5'h00);
  c_slot_stall: cover property (slot_valid && !slot_ready);
endmodule : lft_sva

bind lft_frame_table lft_sva #(.NF(NF)) u_sva (.clk, .rstn, .cfg_we, .cfg_target, .cfg_frame, .cfg_size, .cfg_sig,
  .cfg_err, .master_mode, .hdr_valid, .m_valid, .m_event, .m_kind, .m_coll_tbl, .spor_req, .spor_valid, .spor_frame,
  .coll_req, .coll_entry, .coll_valid, .coll_frame, .slot_valid, .slot_ready, .slot_sig, .slot_off);

// >>> verif/tb_top.sv
// Self-checking bench for the frame table
`timescale 1ns/1ps
module tb_top;
  import lft_pkg::*;
  logic clk, rstn, cfg_we, cfg_cks, cfg_assoc, master_mode, hdr_valid, upd_valid, spor_req, coll_req, stall;
  logic cfg_err, m_valid, m_hit, m_event, m_cks, spor_valid, coll_valid, slot_valid, slot_ready, slot_last, walk_busy;
  logic [2:0] cfg_target, coll_entry;
  logic [4:0] cfg_frame, cfg_num, upd_frame, m_frame, m_coll_tbl, spor_frame, coll_frame;
  logic [3:0] cfg_slot, cfg_size, m_size;
  logic [1:0] cfg_kind, m_kind;
  logic [5:0] cfg_id, hdr_id, cfg_off, slot_off;
  logic [7:0] cfg_sig, slot_sig;
  int n_mismatch, comparisons, cyc;

  lft_frame_table dut (.clk, .rstn, .cfg_we, .cfg_target, .cfg_frame, .cfg_slot, .cfg_kind, .cfg_id, .cfg_size,
    .cfg_cks, .cfg_assoc, .cfg_sig, .cfg_off, .cfg_num, .cfg_err, .master_mode, .hdr_valid, .hdr_id, .m_valid, .m_hit,
    .m_event, .m_frame, .m_kind, .m_size, .m_cks, .m_coll_tbl, .upd_valid, .upd_frame, .spor_req, .spor_valid,
    .spor_frame, .coll_req, .coll_entry, .coll_valid, .coll_frame, .slot_valid, .slot_ready, .slot_sig, .slot_off,
    .slot_last, .walk_busy);
  lft_node_model node (.clk, .rstn, .slot_valid, .slot_ready, .slot_sig, .slot_off, .slot_last, .stall);

  // ****************************************
  // Clock, timeout and report
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // A hang ends the run as a failure
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // ****************************************
  // Port drivers
  // ****************************************
  // One idle edge between writes keeps the strobe a clean pulse
  task automatic wr(logic [2:0] t, logic [4:0] f, logic [3:0] s, logic [1:0] k, logic [5:0] id, logic [3:0] sz,
                    logic c, logic a, logic [7:0] sg, logic [5:0] of, logic [4:0] n, logic e);
    @(posedge clk);
    #1;
    {cfg_we, cfg_target, cfg_frame, cfg_slot, cfg_kind, cfg_id} = {1'b1, t, f, s, k, id};
    {cfg_size, cfg_cks, cfg_assoc, cfg_sig, cfg_off, cfg_num} = {sz, c, a, sg, of, n};
    @(posedge clk);
    #1;
    cfg_we = 1'b0;
    chk("cfg_err", 16'(e), 16'(cfg_err));
  endtask : wr

  task automatic wf(logic [4:0] f, logic [1:0] k, logic [5:0] id, logic [3:0] sz, logic c, logic a, logic e);
    wr(TGT_FRAME, f, 4'h0, k, id, sz, c, a, 8'h00, 6'h00, 5'h00, e);
  endtask : wf

  task automatic wn(logic [2:0] t, logic [3:0] s, logic [4:0] n, logic e);
    wr(t, 5'h01, s, KIND_PUBLISH, 6'h00, 4'h1, 1'b0, 1'b0, 8'h00, 6'h00, n, e);
  endtask : wn

  // Header, update, sporadic and collision requests are one-cycle pulses
  task automatic hm(logic [5:0] id);
    @(posedge clk);
    #1;
    {hdr_valid, hdr_id} = {1'b1, id};
    @(posedge clk);
    #1;
    hdr_valid = 1'b0;
    chk("m_valid", 16'h0001, 16'(m_valid));
  endtask : hm

  task automatic up(logic [4:0] f);
    @(posedge clk);
    #1;
    {upd_valid, upd_frame} = {1'b1, f};
    @(posedge clk);
    #1;
    upd_valid = 1'b0;
  endtask : up

  task automatic sp(logic [4:0] e);
    @(posedge clk);
    #1;
    spor_req = 1'b1;
    @(posedge clk);
    #1;
    spor_req = 1'b0;
    chk("spor", {11'h001, e}, {10'h000, spor_valid, spor_frame});
  endtask : sp

  task automatic cq(logic [2:0] n, logic [4:0] e);
    @(posedge clk);
    #1;
    {coll_req, coll_entry} = {1'b1, n};
    @(posedge clk);
    #1;
    coll_req = 1'b0;
    chk("coll", {11'h001, e}, {10'h000, coll_valid, coll_frame});
  endtask : cq

  // Slot k of the streamed frame: {signal, offset, last}; slot 7 unused
  function automatic logic [14:0] slot_exp(int k);
    if (k == 7)
      return {8'h00, 6'h05, 1'b0};
    if (k == 14)
      return {SIG_MAX, 6'h3f, 1'b1};
    return {8'(k + 1), 6'(k * 4), 1'b0};
  endfunction : slot_exp

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_frames();
    hm(6'h00);
    chk("m_hit", 16'h0000, 16'(m_hit));
    chk("m_size", 16'h0001, 16'(m_size));
    chk("m_cks", 16'h0000, 16'(m_cks));
    for (int i = 0; i < 4; i++)
    begin
      wf(i[0] ? FRAME_MAX : 5'h01, i[1] ? KIND_SUBSCRIBE : KIND_PUBLISH, 6'(8'h38 + i), i[0] ? SIZE_MAX : SIZE_MIN,
         i[1], 1'b0, 1'b0);
      hm(6'(8'h38 + i));
      chk("match", {2'h0, 1'b1, i[0] ? FRAME_MAX : 5'h01, i[1] ? KIND_SUBSCRIBE : KIND_PUBLISH,
          i[0] ? SIZE_MAX : SIZE_MIN, i[1]}, {2'h0, m_hit, m_frame, m_kind, m_size, m_cks});
    end
    wf(5'h1a, KIND_PUBLISH, 6'h10, 4'h1, 1'b0, 1'b0, 1'b1);
    wf(5'h02, KIND_PUBLISH, 6'h10, 4'h0, 1'b0, 1'b0, 1'b1);
    wf(5'h02, KIND_PUBLISH, 6'h10, 4'h9, 1'b0, 1'b0, 1'b1);
    wf(5'h02, 2'h3, 6'h10, 4'h1, 1'b0, 1'b0, 1'b1);
    hm(6'h10);
    chk("m_hit", 16'h0000, 16'(m_hit));
  endtask : t_frames

  task automatic t_event();
    wf(5'h02, KIND_SUBSCRIBE, 6'h21, 4'h4, CKS_ENHANCED, 1'b1, 1'b0);
    wr(TGT_ETF, 5'h01, 4'h0, KIND_SUBSCRIBE, 6'h30, 4'h4, CKS_ENHANCED, 1'b0, 8'h00, 6'h00, 5'h01, 1'b0);
    wr(TGT_ETF, 5'h01, 4'h0, KIND_SUBSCRIBE, 6'h30, 4'h4, CKS_ENHANCED, 1'b0, 8'h00, 6'h00, 5'h02, 1'b1);
    hm(6'h30);
    chk("m_event", 16'h0000, 16'(m_event));
    wn(TGT_ETF_REF, 4'h4, 5'h02, 1'b0);
    wn(TGT_ETF_REF, 4'h5, 5'h02, 1'b1);
    wn(TGT_ETF_REF, 4'h0, 5'h1a, 1'b1);
    wn(TGT_COLL, 4'h0, 5'h02, 1'b0);
    wn(TGT_COLL, 4'h4, FRAME_MAX, 1'b0);
    master_mode = 1'b1;
    hm(6'h30);
    chk("event", 16'h0021, {10'h000, m_event, m_coll_tbl});
    cq(3'h0, 5'h02);
    cq(3'h4, FRAME_MAX);
    cq(3'h5, 5'h00);
    master_mode = 1'b0;
    hm(6'h30);
    chk("event", 16'h0020, {10'h000, m_event, m_coll_tbl});
    cq(3'h0, 5'h00);
  endtask : t_event

  // Fourteen used slots overflow the eight-word buffer while the node stalls
  task automatic t_stream();
    logic [14:0] e;
    int j;
    stall = 1'b1;
    wf(5'h04, KIND_PUBLISH, 6'h04, 4'h8, CKS_CLASSIC, 1'b0, 1'b0);
    for (int k = 0; k < 15; k++)
    begin
      e = slot_exp(k);
      wr(TGT_SIGNAL, 5'h04, 4'(k), 2'h0, 6'h00, 4'h1, 1'b0, 1'b0, e[14:7], e[6:1], 5'h00, 1'b0);
    end
    wr(TGT_SIGNAL, 5'h04, 4'hf, 2'h0, 6'h00, 4'h1, 1'b0, 1'b0, 8'h01, 6'h00, 5'h00, 1'b1);
    wr(TGT_SIGNAL, 5'h04, 4'h0, 2'h0, 6'h00, 4'h1, 1'b0, 1'b0, 8'h83, 6'h00, 5'h00, 1'b1);
    hm(6'h04);
    repeat (20) @(posedge clk);
    #1;
    chk("stalled", 16'h0003, {14'h0000, slot_valid, walk_busy});
    stall = 1'b0;
    // Flags are read off the edge, once the registers have settled
    for (int w = 0; w < 40 && (walk_busy || slot_valid); w++)
    begin
      @(posedge clk);
      #1;
    end
    chk("count", 16'h000e, 16'(node.got.size()));
    j = 0;
    for (int k = 0; k < 15 && j < node.got.size(); k++)
      if (k != 7)
      begin
        chk("slot", 16'(slot_exp(k)), 16'(node.got[j]));
        j++;
      end
  endtask : t_stream

  task automatic t_spor();
    master_mode = 1'b1;
    wn(TGT_SPOR_REF, 4'h0, 5'h05, 1'b0);
    wn(TGT_SPOR_REF, 4'h2, 5'h06, 1'b0);
    wn(TGT_SPOR_REF, 4'h5, 5'h06, 1'b1);
    wn(TGT_SPOR_REF, 4'h1, 5'h1a, 1'b1);
    up(5'h06);
    up(5'h05);
    sp(5'h00);
    wn(TGT_SPOR, 4'h0, 5'h00, 1'b0);
    sp(5'h05);
    sp(5'h06);
    sp(5'h00);
    master_mode = 1'b0;
    up(5'h05);
    sp(5'h00);
  endtask : t_spor

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rstn, cfg_we, cfg_cks, cfg_assoc, master_mode, hdr_valid, upd_valid, spor_req, coll_req, stall} = '0;
    {cfg_target, coll_entry, cfg_frame, cfg_num, upd_frame, cfg_slot, cfg_size, cfg_kind} = '0;
    {cfg_id, hdr_id, cfg_off, cfg_sig} = '0;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(posedge clk);
    #1;
    chk("reset", 16'h0002, {10'h000, cfg_err, m_size, slot_valid});
    t_frames();
    t_event();
    t_stream();
    t_spor();
    complete_run();
  end
endmodule : tb_top
